// >>> core/adc_sel_defs.svh
// Register map, field positions, reset values and timing of the channel select block
`ifndef ADC_SEL_DEFS_SVH
`define ADC_SEL_DEFS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_STATUS 3'h0
`define IDX_MODE 3'h1
`define IDX_CONFIG 3'h2
`define IDX_RESULT 3'h3
`define IDX_IRQ_STATUS 3'h4
`define IDX_IRQ_MASK 3'h5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CFG_NEG_LSB 0
`define CFG_POS_LSB 4
`define CFG_PSEUDO_BIT 8
`define MODE_APPEND_BIT 0
`define STAT_READY_BIT 7
`define IRQ_DONE_BIT 0
`define IRQ_OVERRUN_BIT 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CONFIG 9'h000
`define RST_MODE 1'h0
`define RST_RESULT 24'h000000
`define RST_CHAN 4'h0
`define RST_READY_N 1'h1
`define RST_IRQ 2'h0

// ----------------------------------------
// Bus answer timing
// ----------------------------------------
`define APB_WAIT_CYCLES 1

`endif

// >>> core/adc_sel_pkg.sv
// Types used by the channel select block
package adc_sel_pkg;

    typedef logic [3:0] chan_t;
    typedef logic [23:0] result_t;
    typedef logic [1:0] irq_t;

    typedef enum logic [1:0] {
        NEG_FROM_CODE = 2'b00,
        NEG_FROM_COMMON = 2'b01
    } neg_src_e;

endpackage

// >>> core/adc_channel_select.sv
// Channel enable decode, conversion result register and APB slave
`timescale 1ns/100ps
`include "adc_sel_defs.svh"

module adc_channel_select (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Converter core
    input wire logic CONV_DONE,
    input wire logic [23:0] CONV_RESULT,
    // Analog multiplexer control
    output logic [3:0] POS_MUX_SEL,
    output logic [3:0] NEG_MUX_SEL,
    output logic NEG_COMMON,
    // Result indication and interrupt
    output logic RESULT_READY_N,
    output logic IRQ
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [8:0] config_reg;
    logic [8:0] next_config_reg;
    logic append_status_enable;
    logic next_append_status_enable;
    adc_sel_pkg::result_t conversion_result;
    adc_sel_pkg::result_t next_conversion_result;
    adc_sel_pkg::chan_t result_channel_code;
    adc_sel_pkg::chan_t next_result_channel_code;
    logic ready_n;
    logic next_ready_n;
    adc_sel_pkg::irq_t irq_status;
    adc_sel_pkg::irq_t next_irq_status;
    adc_sel_pkg::irq_t irq_mask;
    adc_sel_pkg::irq_t next_irq_mask;
    logic [3:0] pos_sel;
    logic [3:0] next_pos_sel;
    logic [3:0] neg_sel;
    logic [3:0] next_neg_sel;
    logic neg_common;
    logic next_neg_common;
    adc_sel_pkg::neg_src_e neg_src;
    logic [31:0] prdata;
    logic [31:0] next_prdata;
    logic pready;
    logic next_pready;
    logic pslverr;
    logic next_pslverr;
    logic irq;
    logic next_irq;
    logic [2:0] reg_index;
    logic addr_mapped;
    logic access_done;
    logic wr_done;
    logic rd_done;
    logic [7:0] status_byte;
    logic [31:0] read_word;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    assign reg_index = PADDR[4:2];
    assign addr_mapped = (PADDR[1:0] == 2'h0) && (PADDR[7:5] == 3'h0)
        && (reg_index <= `IDX_IRQ_MASK);
    // A transfer completes only at the edge that samples PREADY high
    assign access_done = PSEL && PENABLE && pready;
    assign wr_done = access_done && PWRITE && addr_mapped;
    assign rd_done = access_done && !PWRITE && addr_mapped;

    // Status byte: ready flag on top, channel code in the low nibble
    always_comb begin
        status_byte = 8'h00;
        status_byte[`STAT_READY_BIT] = ready_n;
        status_byte[3:0] = result_channel_code;
    end

    always_comb begin
        read_word = 32'h00000000;
        unique case (reg_index)
            `IDX_STATUS: begin
                read_word = {24'h000000, status_byte};
            end
            `IDX_MODE: begin
                read_word[`MODE_APPEND_BIT] = append_status_enable;
            end
            `IDX_CONFIG: begin
                read_word = {23'h000000, config_reg};
            end
            `IDX_RESULT: begin
                // With append set, result in the top 24 bits, status byte last, so a
                // word read is the 32-bit serial frame order
                if (append_status_enable) begin
                    read_word = {conversion_result, status_byte};
                end else begin
                    read_word = {8'h00, conversion_result};
                end
            end
            `IDX_IRQ_STATUS: begin
                read_word = {30'h00000000, irq_status};
            end
            `IDX_IRQ_MASK: begin
                read_word = {30'h00000000, irq_mask};
            end
            default: begin
                read_word = 32'h00000000;
            end
        endcase
    end

    // ----------------------------------------
    // APB answer
    // ----------------------------------------
    // One wait state keeps PRDATA and PREADY straight from flip-flops
    always_comb begin
        next_pready = PSEL && PENABLE && !pready;
        next_pslverr = 1'b0;
        next_prdata = 32'h00000000;
        if (PSEL && PENABLE && !pready) begin
            next_pslverr = !addr_mapped;
            if (!PWRITE && addr_mapped) begin
                next_prdata = read_word;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    // ----------------------------------------
    // Configuration and mode registers
    // ----------------------------------------
    always_comb begin
        next_config_reg = config_reg;
        next_append_status_enable = append_status_enable;
        next_irq_mask = irq_mask;
        if (wr_done) begin
            unique case (reg_index)
                `IDX_CONFIG: begin
                    next_config_reg = PWDATA[8:0];
                end
                `IDX_MODE: begin
                    next_append_status_enable = PWDATA[`MODE_APPEND_BIT];
                end
                `IDX_IRQ_MASK: begin
                    next_irq_mask = PWDATA[1:0];
                end
                default: begin
                    next_config_reg = config_reg;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            config_reg <= `RST_CONFIG;
            append_status_enable <= `RST_MODE;
            irq_mask <= `RST_IRQ;
        end else begin
            config_reg <= next_config_reg;
            append_status_enable <= next_append_status_enable;
            irq_mask <= next_irq_mask;
        end
    end

    // ----------------------------------------
    // Multiplexer decode
    // ----------------------------------------
    assign neg_src = config_reg[`CFG_PSEUDO_BIT]
        ? adc_sel_pkg::NEG_FROM_COMMON : adc_sel_pkg::NEG_FROM_CODE;

    // Select code n drives analog input n+1 on each side
    always_comb begin
        next_pos_sel = config_reg[`CFG_POS_LSB +: 4];
        next_neg_sel = 4'h0;
        next_neg_common = 1'b0;
        unique case (neg_src)
            adc_sel_pkg::NEG_FROM_CODE: begin
                next_neg_sel = config_reg[`CFG_NEG_LSB +: 4];
            end
            adc_sel_pkg::NEG_FROM_COMMON: begin
                // Lower code ignored; selector parked at zero
                next_neg_common = 1'b1;
            end
        endcase
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            pos_sel <= 4'h0;
            neg_sel <= 4'h0;
            neg_common <= 1'b0;
        end else begin
            pos_sel <= next_pos_sel;
            neg_sel <= next_neg_sel;
            neg_common <= next_neg_common;
        end
    end

    // ----------------------------------------
    // Result register and ready flag
    // ----------------------------------------
    // Channel code is taken from the mux setting in force for the
    // conversion, not the one written afterwards
    always_comb begin
        next_conversion_result = conversion_result;
        next_result_channel_code = result_channel_code;
        next_ready_n = ready_n;
        if (rd_done && (reg_index == `IDX_RESULT)) begin
            next_ready_n = 1'b1;
        end
        // New result wins over a read finishing in the same cycle
        if (CONV_DONE) begin
            next_conversion_result = CONV_RESULT;
            next_result_channel_code = pos_sel;
            next_ready_n = 1'b0;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            conversion_result <= `RST_RESULT;
            result_channel_code <= `RST_CHAN;
            ready_n <= `RST_READY_N;
        end else begin
            conversion_result <= next_conversion_result;
            result_channel_code <= next_result_channel_code;
            ready_n <= next_ready_n;
        end
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    // Overrun: a result arrives while the previous one is unread
    always_comb begin
        next_irq_status = irq_status;
        if (wr_done && (reg_index == `IDX_IRQ_STATUS)) begin
            next_irq_status = irq_status & ~PWDATA[1:0];
        end
        if (CONV_DONE) begin
            next_irq_status[`IRQ_DONE_BIT] = 1'b1;
            if (!ready_n) begin
                next_irq_status[`IRQ_OVERRUN_BIT] = 1'b1;
            end
        end
        next_irq = |(next_irq_status & irq_mask);
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            irq_status <= `RST_IRQ;
            irq <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq <= next_irq;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign PRDATA = prdata;
    assign PREADY = pready;
    assign PSLVERR = pslverr;
    assign POS_MUX_SEL = pos_sel;
    assign NEG_MUX_SEL = neg_sel;
    assign NEG_COMMON = neg_common;
    assign RESULT_READY_N = ready_n;
    assign IRQ = irq;

endmodule

// >>> bench/adc_host_model.sv
// Host model: APB master that reaches the block's registers
`timescale 1ns/100ps
module adc_host_model (
    // Clock
    input wire logic clk,
    // APB master
    output logic psel = 1'h0,
    output logic penable = 1'h0,
    output logic pwrite = 1'h0,
    output logic [7:0] paddr = 8'h00,
    output logic [31:0] pwdata = 32'h0,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e, output logic ok);
        int n = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        // Read at the rising edge, before that edge's own register updates land
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        q = prdata;
        e = pslverr;
        ok = (pready === 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
        // Released lines change so a stale value is never mistaken for a live one
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// >>> bench/adc_sel_props.sv
// Port assertions for the channel select block
`timescale 1ns/100ps
module adc_sel_props (
    // Clock, reset and bus
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Converter, mux and flags
    input wire logic CONV_DONE,
    input wire logic [23:0] CONV_RESULT,
    input wire logic [3:0] POS_MUX_SEL,
    input wire logic [3:0] NEG_MUX_SEL,
    input wire logic NEG_COMMON,
    input wire logic RESULT_READY_N,
    input wire logic IRQ
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);
    logic done, wcfg, rres, rsta, app, cd1;
    logic [3:0] chan;
    logic [23:0] res;
    assign done = PSEL && PENABLE && PREADY && !PSLVERR;
    assign wcfg = done && PWRITE && PADDR == 8'h08;
    // Reads right after a strobe see older data, so they are left out
    assign rres = done && !PWRITE && PADDR == 8'h0C && !cd1;
    assign rsta = done && !PWRITE && PADDR == 8'h00 && !cd1;
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            app <= 1'h0;
            cd1 <= 1'h0;
            chan <= 4'h0;
            res <= 24'h0;
        end else begin
            app <= (done && PWRITE && PADDR == 8'h04) ? PWDATA[0] : app;
            cd1 <= CONV_DONE;
            chan <= CONV_DONE ? POS_MUX_SEL : chan;
            res <= CONV_DONE ? CONV_RESULT : res;
        end
    end
    pos_sel_a: assert property (wcfg |-> ##2 POS_MUX_SEL == $past(PWDATA[7:4], 2))
        else $error("pos sel");
    neg_sel_a: assert property (wcfg && !PWDATA[8] |->
        ##2 NEG_MUX_SEL == $past(PWDATA[3:0], 2))
        else $error("neg sel");
    common_neg_a: assert property (wcfg && PWDATA[8] |->
        ##2 NEG_COMMON && NEG_MUX_SEL == 4'h0)
        else $error("common");
    chan_code_a: assert property (rsta |-> PRDATA[3:0] == chan)
        else $error("chan code");
    result_word_a: assert property (rres && !app |-> PRDATA == {8'h00, res})
        else $error("result");
    ready_set_a: assert property (rres && !CONV_DONE |=> RESULT_READY_N)
        else $error("ready");
    append_res_a: assert property (rres && app |-> PRDATA[31:8] == res)
        else $error("append");
    status_byte_a: assert property (rres && app |->
        PRDATA[3:0] == chan && PRDATA[7] == RESULT_READY_N)
        else $error("status byte");
    cover property (rres && app);
    cover property (wcfg && PWDATA[8]);
    cover property (CONV_DONE && !RESULT_READY_N);
endmodule
bind adc_channel_select adc_sel_props props (
    .CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CONV_DONE(CONV_DONE), .CONV_RESULT(CONV_RESULT), .POS_MUX_SEL(POS_MUX_SEL),
    .NEG_MUX_SEL(NEG_MUX_SEL), .NEG_COMMON(NEG_COMMON), .RESULT_READY_N(RESULT_READY_N),
    .IRQ(IRQ)
);

// >>> bench/tb_adc_channel_select.sv
// Self-checking bench for the channel select block
`timescale 1ns/100ps
module tb_adc_channel_select;
    logic CLOCK = 1'h0;
    logic RST_N = 1'h0;
    logic CONV_DONE = 1'h0;
    logic [23:0] CONV_RESULT = 24'h0;
    logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, NEG_COMMON, RESULT_READY_N, IRQ;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA;
    logic [3:0] POS_MUX_SEL, NEG_MUX_SEL;
    logic [32:0] mux;
    int num_errors = 0;
    int comparisons = 0;
    assign mux = {24'h0, POS_MUX_SEL, NEG_MUX_SEL, NEG_COMMON};
    always #5 CLOCK = ~CLOCK;
    adc_channel_select DUT (
        .CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .CONV_DONE(CONV_DONE), .CONV_RESULT(CONV_RESULT), .POS_MUX_SEL(POS_MUX_SEL),
        .NEG_MUX_SEL(NEG_MUX_SEL), .NEG_COMMON(NEG_COMMON), .RESULT_READY_N(RESULT_READY_N),
        .IRQ(IRQ)
    );
    adc_host_model hm (.clk(CLOCK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE),
        .paddr(PADDR), .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR));
    task automatic give_verdict();
        $display("Errors %0d, checks %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask
    // Writes read back zero, so one compare covers data and error
    task automatic io(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] exp, input logic err);
        logic [31:0] q;
        logic e;
        logic ok;
        hm.xfer(w, a, d, q, e, ok);
        if (ok !== 1'h1) begin
            num_errors++;
            give_verdict();
        end
        chk({e, q}, {err, exp});
    endtask
    function automatic logic [31:0] rword(input logic ap, input logic [23:0] r,
                                          input logic [3:0] c);
        return ap ? {r, 4'h0, c} : {8'h00, r};
    endfunction
    task automatic conv(input logic [23:0] r);
        @(posedge CLOCK);
        CONV_DONE <= 1'h1;
        CONV_RESULT <= r;
        @(posedge CLOCK);
        CONV_DONE <= 1'h0;
        repeat (2) @(negedge CLOCK);
    endtask
    initial begin
        logic [3:0] p, n, m;
        logic [23:0] r;
        logic ap, ps;
        void'($urandom(74657));
        repeat (12) @(posedge CLOCK);
        RST_N <= 1'h1;
        @(negedge CLOCK);
        chk({22'h0, POS_MUX_SEL, NEG_MUX_SEL, NEG_COMMON, RESULT_READY_N, IRQ}, 33'h2);
        io(1'h1, 8'h0C, 32'hFFFFFFFF, 32'h0, 1'h0);
        io(1'h0, 8'h0C, 32'h0, 32'h0, 1'h0);
        io(1'h0, 8'h00, 32'h0, 32'h80, 1'h0);
        io(1'h0, 8'h18, 32'h0, 32'h0, 1'h1);
        io(1'h0, 8'h02, 32'h0, 32'h0, 1'h1);
        io(1'h1, 8'h14, 32'h1, 32'h0, 1'h0);
        for (int i = 0; i < 32; i++) begin
            p = i[3:0];
            ps = i[4];
            n = 4'($urandom);
            r = 24'($urandom);
            m = ps ? 4'h0 : n;
            ap = (i >= 8);
            io(1'h1, 8'h04, {31'h0, ap}, 32'h0, 1'h0);
            io(1'h1, 8'h08, {23'h0, ps, p, n}, 32'h0, 1'h0);
            repeat (2) @(negedge CLOCK);
            chk(mux, {24'h0, p, m, ps});
            conv(r);
            chk({32'h0, IRQ}, 33'h1);
            io(1'h0, 8'h00, 32'h0, {28'h0, p}, 1'h0);
            io(1'h0, 8'h0C, 32'h0, rword(ap, r, p), 1'h0);
            @(negedge CLOCK);
            chk({32'h0, RESULT_READY_N}, 33'h1);
            io(1'h1, 8'h10, 32'h1, 32'h0, 1'h0);
            io(1'h0, 8'h10, 32'h0, 32'h0, 1'h0);
            chk({32'h0, IRQ}, 33'h0);
        end
        io(1'h1, 8'h14, 32'h0, 32'h0, 1'h0);
        conv(24'hA5A5A5);
        conv(24'h5A5A5A);
        chk({32'h0, IRQ}, 33'h0);
        io(1'h0, 8'h10, 32'h0, 32'h3, 1'h0);
        io(1'h1, 8'h14, 32'h2, 32'h0, 1'h0);
        repeat (2) @(negedge CLOCK);
        chk({32'h0, IRQ}, 33'h1);
        io(1'h0, 8'h0C, 32'h0, rword(1'h1, 24'h5A5A5A, p), 1'h0);
        give_verdict();
    end
endmodule
